// >>> design/updown_counter.sv
`timescale 1ns/1ns
// Functional notes
// RULE1 - Four-bit count wraps modulo sixteen both ways
// RULE2 - Low load copies preset, overrides counting
// RULE3 - Count changes only on clock rise, enabled
// RULE4 - Direction low counts up, high down
// RULE5 - Enable and direction act only at edge
// RULE6 - Flag high at 15 up, 0 down
// RULE7 - Flag follows count and direction changes
// RULE8 - Never use terminal flag as a clock
// RULE9 - Strobe idles high, low in clock low
// RULE10 - Strobe returns high after clock rises
// RULE11 - High enable suppresses strobe pulse
// RULE12 - Ripple cascade feeds strobe to next clock
// RULE13 - Shared clock low outlasts carry ripple
// RULE14 - Look-ahead enable from preceding terminal flags; driver enable comes from global_enable_in alone
// RULE15 - Look-ahead gates need a global enable
// RULE16 - Low load forces strobe high
// RULE17 - Count presented continuously, bit zero LSB
module updown_counter (
	// System
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Link
	updown_if.counter link
);
	import updown_pkg::*;

	// Mode seen at one clk_in edge, Gray along hold, up, down, load
	typedef enum logic [1:0] {
		MODE_HOLD = 2'h0,
		MODE_UP   = 2'h1,
		MODE_DOWN = 2'h3,
		MODE_LOAD = 2'h2
	} count_mode_t;

	// State
	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] count_next;
	logic                   cp_prev_reg;
	logic                   cp_prev_next;
	logic                   flag_reg;
	logic                   flag_next;
	logic                   strobe_n_reg;
	logic                   strobe_n_next;
	// Decoded link controls
	count_mode_t            mode;
	wire                    cp_rise;
	wire                    cp_fall;
	wire                    load_now;
	wire                    enable_now;
	wire                    down_now;
	wire [COUNT_WIDTH-1:0]  preset_now;
	wire                    count_edge;
	wire                    strobe_arm;
	wire [COUNT_WIDTH-1:0]  count_stepped;

	function automatic logic [COUNT_WIDTH-1:0] step(
		input logic [COUNT_WIDTH-1:0] v,
		input logic                   down
	);
		if (down) begin
			step = v - COUNT_STEP; // [RULE1] [RULE4]
		end else begin
			step = v + COUNT_STEP; // [RULE1] [RULE4]
		end
	endfunction

	function automatic logic at_terminal(
		input logic [COUNT_WIDTH-1:0] v,
		input logic                   down
	);
		if (down) begin
			at_terminal = (v == COUNT_MIN); // [RULE6]
		end else begin
			at_terminal = (v == COUNT_MAX); // [RULE6]
		end
	endfunction

	// Load beats enable, enable gates direction
	function automatic count_mode_t mode_of(
		input logic load_n,
		input logic enable_n,
		input logic down
	);
		if (!load_n) begin
			mode_of = MODE_LOAD; // [RULE2]
		end else if (enable_n) begin
			mode_of = MODE_HOLD; // [RULE3]
		end else if (down) begin
			mode_of = MODE_DOWN; // [RULE4]
		end else begin
			mode_of = MODE_UP; // [RULE4]
		end
	endfunction

	// Edge of the link clock against its value one cycle earlier
	function automatic logic edge_of(
		input logic now,
		input logic prev,
		input logic rising
	);
		if (rising) begin
			edge_of = now & ~prev;
		end else begin
			edge_of = ~now & prev;
		end
	endfunction

	assign cp_rise       = edge_of(link.clock_pulse, cp_prev_reg, 1'b1);
	assign cp_fall       = edge_of(link.clock_pulse, cp_prev_reg, 1'b0);
	assign cp_prev_next  = link.clock_pulse;
	assign load_now      = ~link.async_load_n;
	assign enable_now    = ~link.count_enable_n;
	assign down_now      = link.down_select;
	assign preset_now    = link.preset_value;
	assign mode          = mode_of(link.async_load_n,
		link.count_enable_n, down_now);
	assign count_stepped = step(count_reg, down_now);
	// Enable and direction only looked at on the rising edge
	assign count_edge    = cp_rise & enable_now; // [RULE3] [RULE5]

	// Load is sampled like any input, so it takes effect one cycle on
	always_comb begin
		case (mode)
			MODE_LOAD: begin
				count_next = preset_now; // [RULE2]
			end
			MODE_UP: begin
				if (count_edge) begin
					count_next = count_stepped; // [RULE4]
				end else begin
					count_next = count_reg;
				end
			end
			MODE_DOWN: begin
				if (count_edge) begin
					count_next = count_stepped; // [RULE4]
				end else begin
					count_next = count_reg;
				end
			end
			MODE_HOLD: begin
				count_next = count_reg; // [RULE3]
			end
			default: begin
				count_next = count_reg;
			end
		endcase
	end

	// Decoded from count and direction each cycle; tracks both
	assign flag_next = at_terminal(count_next, down_now); // [RULE6] [RULE7]

	// Arms only on a clock fall seen while enabled at terminal count
	assign strobe_arm = cp_fall & enable_now & flag_reg; // [RULE9]

	// Load, clock rise or disable all end the low pulse at once
	always_comb begin
		if (load_now) begin
			strobe_n_next = 1'b1; // [RULE16]
		end else if (cp_rise) begin
			strobe_n_next = 1'b1; // [RULE10]
		end else if (strobe_arm) begin
			strobe_n_next = 1'b0; // [RULE9]
		end else if (link.count_enable_n) begin
			strobe_n_next = 1'b1; // [RULE11]
		end else begin
			strobe_n_next = strobe_n_reg;
		end
	end

	// Count register feeds the outputs directly
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			count_reg <= COUNT_RESET;
		end else begin
			count_reg <= count_next; // [RULE1]
		end
	end

	// Clears low so a clock idling low gives no false edge
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cp_prev_reg <= 1'b0;
		end else begin
			cp_prev_reg <= cp_prev_next;
		end
	end

	// Flag lands in the same cycle as the count it decodes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next; // [RULE6]
		end
	end

	// Strobe idles high out of reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			strobe_n_reg <= 1'b1;
		end else begin
			strobe_n_reg <= strobe_n_next; // [RULE9]
		end
	end

	// Outputs come straight from flip-flops
	assign link.count_value     = count_reg;    // [RULE17]
	assign link.terminal_flag   = flag_reg;     // [RULE6]
	assign link.ripple_strobe_n = strobe_n_reg; // [RULE9]
endmodule

// >>> design/updown_pkg.sv
package updown_pkg;
	localparam int unsigned COUNT_WIDTH = 4;
	localparam logic [3:0]  COUNT_MAX   = 4'hF;
	localparam logic [3:0]  COUNT_MIN   = 4'h0;
	localparam logic [3:0]  COUNT_RESET = 4'h0;
	localparam logic [3:0]  COUNT_STEP  = 4'h1;
	// Clock divider: the counter clock is a square wave with a period of this many cycles
	localparam int unsigned CLK_DIV     = 4;
endpackage

// >>> design/updown_if.sv
`timescale 1ns/1ns
interface updown_if;
	logic       clock_pulse;
	logic       count_enable_n;
	logic       down_select;
	logic       async_load_n;
	logic [3:0] preset_value;
	logic [3:0] count_value;
	logic       terminal_flag;
	logic       ripple_strobe_n;

	modport counter (
		input  clock_pulse, count_enable_n, down_select, async_load_n,
		input  preset_value,
		output count_value, terminal_flag, ripple_strobe_n
	);
	modport driver (
		output clock_pulse, count_enable_n, down_select, async_load_n,
		output preset_value,
		input  count_value, terminal_flag, ripple_strobe_n
	);
endinterface

// >>> design/updown_driver.sv
`timescale 1ns/1ns
module updown_driver (
	// System
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	// User controls
	input  wire logic                   run_in,
	input  wire logic                   global_enable_in,
	input  wire logic                   down_in,
	input  wire logic                   load_in,
	input  wire logic [updown_pkg::COUNT_WIDTH-1:0] preset_in,
	// User status
	output logic [updown_pkg::COUNT_WIDTH-1:0]      count_out,
	output logic                        terminal_out,
	output logic                        carry_out,
	// Link
	updown_if.driver                    link
);
	import updown_pkg::*;

	logic [$clog2(CLK_DIV)-1:0] div_reg;
	logic                       cp_reg;
	logic                       enable_n_reg;
	logic                       down_reg;
	logic                       load_n_reg;
	logic [COUNT_WIDTH-1:0]     preset_reg;
	logic                       strobe_prev_reg;
	wire                        div_wrap;
	wire                        strobe_rise;

	assign div_wrap    = (div_reg == ($clog2(CLK_DIV))'(CLK_DIV - 1));
	assign strobe_rise = link.ripple_strobe_n & ~strobe_prev_reg;

	// Square wave while run_in is high, held low otherwise; low half is one divider half period
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			div_reg <= '0;
			cp_reg  <= 1'b0;
		end else begin
			div_reg <= div_wrap ? '0 : div_reg + 1'b1;
			if (div_wrap || div_reg == ($clog2(CLK_DIV))'(CLK_DIV/2 - 1))
				cp_reg <= run_in ? ~cp_reg : 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			enable_n_reg    <= 1'b1;
			down_reg        <= 1'b0;
			load_n_reg      <= 1'b1;
			preset_reg      <= COUNT_RESET;
			strobe_prev_reg <= 1'b1;
			count_out       <= COUNT_RESET;
			terminal_out    <= 1'b0;
			carry_out       <= 1'b0;
		end else begin
			// Global enable alone drives count enable, no terminal-flag look-ahead [RULE15] [RULE14]
			enable_n_reg    <= ~global_enable_in;
			down_reg        <= down_in;
			load_n_reg      <= ~load_in;
			preset_reg      <= preset_in;
			strobe_prev_reg <= link.ripple_strobe_n;
			count_out       <= link.count_value;
			// Flag only sampled, never used as a clock [RULE8]
			terminal_out    <= link.terminal_flag;
			carry_out       <= strobe_rise;   // [RULE12]
		end
	end

	// Low phase of CLK_DIV/2 cycles covers one stage of carry [RULE13]
	assign link.clock_pulse    = cp_reg;
	assign link.count_enable_n = enable_n_reg;
	assign link.down_select    = down_reg;
	assign link.async_load_n   = load_n_reg;
	assign link.preset_value   = preset_reg;
endmodule

// >>> bench/updown_properties.sv
`timescale 1ns/1ns
module updown_properties (
	// System
	input wire logic       clk_in,
	input wire logic       srst_in,
	// Link
	input wire logic       clock_pulse,
	input wire logic       count_enable_n,
	input wire logic       down_select,
	input wire logic       async_load_n,
	input wire logic [3:0] preset_value,
	input wire logic [3:0] count_value,
	input wire logic       terminal_flag,
	input wire logic       ripple_strobe_n
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	wire logic at_end = down_select ? count_value == 4'h0 : count_value == 4'hF;
	sequence s_step;
		$rose(clock_pulse) && !count_enable_n && async_load_n;
	endsequence
	AST_COUNT_UP: assert property (s_step ##0 !down_select |=>
		count_value == $past(count_value) + 4'h1) else $error("bad up step");
	AST_COUNT_DOWN: assert property (s_step ##0 down_select |=>
		count_value == $past(count_value) - 4'h1) else $error("bad down step");
	AST_LOAD: assert property (!async_load_n |=>
		count_value == $past(preset_value)) else $error("bad load");
	AST_HOLD: assert property ((count_enable_n || !$rose(clock_pulse)) &&
		async_load_n |=> $stable(count_value)) else $error("count moved");
	AST_FLAG: assert property (($stable(count_value) &&
		$stable(down_select)) [*2] |-> terminal_flag == at_end)
		else $error("bad terminal flag");
	AST_STROBE_LOW: assert property ($fell(clock_pulse) && terminal_flag &&
		!count_enable_n && async_load_n |=> !ripple_strobe_n)
		else $error("strobe did not fall");
	AST_STROBE_HIGH: assert property (clock_pulse |=> ripple_strobe_n)
		else $error("strobe low in high phase");
	AST_STROBE_GATE: assert property (count_enable_n |=> ripple_strobe_n)
		else $error("strobe not gated");
	AST_STROBE_LOAD: assert property (!async_load_n |=> ripple_strobe_n)
		else $error("strobe low in load");
endmodule

// >>> bench/updown_counter_ripple_carry_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, a); failures++; end end
module updown_counter_ripple_carry_tb;
	import updown_pkg::*;
	logic clk_in = 0, srst_in = 1, run = 0, gen = 0, down = 0, load = 0;
	logic [3:0] preset = 4'h0, exp_count = 4'h0, cnt;
	logic last_cp = 0;
	logic term, carry;
	int failures = 0, check_count = 0, cycles = 0;
	int pulses = 0, exp_pulses = 0;
	updown_if link ();
	updown_counter updown_counter_i (.clk_in(clk_in), .srst_in(srst_in), .link(link));
	updown_driver updown_driver_i (.clk_in(clk_in), .srst_in(srst_in),
		.run_in(run), .global_enable_in(gen), .down_in(down), .load_in(load),
		.preset_in(preset), .count_out(cnt), .terminal_out(term),
		.carry_out(carry), .link(link));
	updown_properties updown_properties_i (.clk_in(clk_in), .srst_in(srst_in),
		.clock_pulse(link.clock_pulse), .count_enable_n(link.count_enable_n),
		.down_select(link.down_select), .async_load_n(link.async_load_n),
		.preset_value(link.preset_value), .count_value(link.count_value),
		.terminal_flag(link.terminal_flag),
		.ripple_strobe_n(link.ripple_strobe_n));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// Reference count follows what the link really carries
	always @(posedge clk_in) begin
		last_cp <= link.clock_pulse;
		if (srst_in)
			exp_count <= 4'h0;
		else if (!link.async_load_n)
			exp_count <= link.preset_value;
		else if (link.clock_pulse && !last_cp && !link.count_enable_n)
			exp_count <= link.down_select ? exp_count - 4'h1 : exp_count + 4'h1;
		// A clock fall at terminal count while enabled gives one strobe
		if (!srst_in && link.async_load_n && !link.clock_pulse && last_cp &&
			!link.count_enable_n && (link.down_select ?
			exp_count == 4'h0 : exp_count == 4'hF))
			exp_pulses++;
		if (!srst_in && carry)
			pulses++;
		cycles++;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end
	task automatic settle();
		repeat (4 * CLK_DIV) @(posedge clk_in);
		`CHK("count", exp_count, link.count_value)
		`CHK("strobe", 1'b1, link.ripple_strobe_n)
		`CHK("terminal", (down ? exp_count == 4'h0 : exp_count == 4'hF), term)
		`CHK("user count", exp_count, cnt)
	endtask
	task automatic preload(input logic [3:0] v);
		@(posedge clk_in);
		preset <= v;
		load <= 1;
		repeat (3) @(posedge clk_in);
		load <= 0;
		settle();
		`CHK("preset", v, link.count_value)
	endtask
	task automatic spin(input logic dn, input logic en, input int n);
		@(posedge clk_in);
		down <= dn;
		gen <= en;
		run <= 1;
		repeat (n * CLK_DIV) @(posedge clk_in);
		run <= 0;
		gen <= 0;
		settle();
	endtask
	task automatic summarize();
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		srst_in <= 0;
		preload(4'hD);
		spin(0, 1, 5);
		preload(4'h2);
		spin(1, 1, 5);
		spin(1, 0, 3);
		spin(0, 1, 18);
		`CHK("user count", exp_count, cnt)
		`CHK("carry pulses", exp_pulses, pulses)
		`CHK("pulses seen", 1'b1, (pulses > 0))
		summarize();
	end
endmodule
